/* hdl/usr_pkg.sv */
// Constants and types shared by the shift register block, its assertions and its bench
package usr_pkg;
  localparam int unsigned STAGES = 8;
  localparam int unsigned FEED_W = 2;
  localparam int unsigned FEED_DEPTH = 8;
  localparam int unsigned LEVEL_W = 4;
  localparam int unsigned ADDR_W = 8;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FEED = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  // Control register fields
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CTRL_SEL_LO = 0;
  localparam int unsigned CTRL_SEL_HI = 1;
  localparam int unsigned CTRL_CLR_N = 2;
  localparam int unsigned CTRL_OE_A_N = 3;
  localparam int unsigned CTRL_OE_B_N = 4;
  localparam logic [4:0] CTRL_RST = 5'h1C;
  // Feed word fields
  localparam int unsigned FEED_RIGHT = 0;
  localparam int unsigned FEED_LEFT = 1;
  // Status register fields
  localparam int unsigned STAT_STAGES_LSB = 0;
  localparam int unsigned STAT_LEVEL_LSB = 8;
  localparam int unsigned STAT_DRIVEN = 16;
  localparam logic [7:0] STAGES_RST = 8'h00;
  // Stepping rate of the register clock
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned STEP_PERIOD_NS = 100;
  localparam int unsigned STEP_DIV = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W = 3;
  localparam logic [2:0] DIV_LAST = DIV_W'(STEP_DIV - 1);

  typedef enum logic [1:0] {
    USR_HOLD = 2'b00,
    USR_RIGHT = 2'b01,
    USR_LEFT = 2'b10,
    USR_LOAD = 2'b11
  } usr_mode_e;

  typedef enum logic {
    USR_BUS_IDLE = 1'b0,
    USR_BUS_WR = 1'b1
  } usr_bus_e;
endpackage

/* hdl/usr_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module usr_fifo #(
  parameter int unsigned W = 2,
  parameter int unsigned D = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Filling side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  // Fill level
  output logic [$clog2(D+1)-1:0] level
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  localparam int unsigned CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } usr_fifo_s;

  usr_fifo_s s_r;
  usr_fifo_s s_nxt;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready = (s_r.cnt != CW'(D));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign level = s_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = bump(s_r.wp);
    end
    if (pop)
    begin
      s_nxt.rp = bump(s_r.rp);
    end
    if (push && !pop)
    begin
      s_nxt.cnt = CW'(s_r.cnt + 1'b1);
    end
    else if (pop && !push)
    begin
      s_nxt.cnt = CW'(s_r.cnt - 1'b1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

/* hdl/usr_shift_top.sv */
// Octal universal shift/storage register behind an AHB-Lite slave
//
// What this block does
// - Eight edge-triggered stages, updated only on a register clock edge.
// - Clear low overrides selects and zeroes all stages at the next edge.
// - Load and shifts happen only at an edge; inputs may change otherwise.
// - Either output enable high puts all parallel pins in high impedance.
// - Disabled pin drivers do not stop shift, load, hold or clear.
// - Both selects high turn the pin drivers off regardless of enables.
// - Load mode captures each parallel pin into its stage; others drive pins.
// - Right shift moves right serial input into stage 0, each stage upward.
// - Left shift moves left serial input into stage 7, each stage downward.
// - Both selects low with clear inactive keep the contents unchanged.
// - Stage 0 and stage 7 drive two dedicated serial taps.
// - When enabled, each stage drives its parallel pin.
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module usr_shift_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Parallel pins, split into input, output and enable
  input wire logic [usr_pkg::STAGES-1:0] par_pins_i,
  output logic [usr_pkg::STAGES-1:0] par_pins_o,
  output logic [usr_pkg::STAGES-1:0] par_pins_oe,
  // Serial taps
  output logic low_end_tap,
  output logic high_end_tap
);
  import usr_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [STAGES-1:0] stages;
    logic [STAGES-1:0] pin_oe;
    logic low_tap;
    logic high_tap;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    usr_bus_e bus;
    logic [ADDR_W-1:0] waddr;
    logic [DIV_W-1:0] div;
  } usr_top_s;

  usr_top_s s_r;
  usr_top_s s_nxt;

  logic tick;
  logic edge_now;
  logic accept;
  logic feed_valid;
  logic feed_ready;
  logic step_valid;
  logic [FEED_W-1:0] step_bits;
  logic [LEVEL_W-1:0] feed_level;
  usr_mode_e mode;

  // Pins are driven only with both enables low and not in load mode
  function automatic logic pins_driven(input logic [CTRL_W-1:0] c);
    if (c[CTRL_OE_A_N] || c[CTRL_OE_B_N])
    begin
      pins_driven = 1'b0;
    end
    else if (c[CTRL_SEL_HI] && c[CTRL_SEL_LO])
    begin
      pins_driven = 1'b0;
    end
    else
    begin
      pins_driven = 1'b1;
    end
  endfunction

  // Feed writes stall on a full queue, so both the push and the wait decode this
  function automatic logic is_feed(input logic [ADDR_W-1:0] a);
    is_feed = (a == ADDR_FEED);
  endfunction

  function automatic logic [31:0] read_mux(
    input logic [ADDR_W-1:0] a,
    input usr_top_s st,
    input logic [LEVEL_W-1:0] lvl
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      ADDR_CTRL:
      begin
        v[CTRL_W-1:0] = st.ctrl;
      end
      ADDR_STATE:
      begin
        v[STAT_STAGES_LSB +: STAGES] = st.stages;
        v[STAT_LEVEL_LSB +: LEVEL_W] = lvl;
        v[STAT_DRIVEN] = st.pin_oe[0];
      end
      default:
      begin
        v = 32'h0000_0000;
      end
    endcase
    read_mux = v;
  endfunction

  // Serial input bits queue up here; each register clock edge consumes one
  usr_fifo #(
    .W(FEED_W),
    .D(FEED_DEPTH)
  ) u_feed (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(feed_valid),
    .in_data(hwdata[FEED_W-1:0]),
    .in_ready(feed_ready),
    .out_valid(step_valid),
    .out_data(step_bits),
    .out_ready(tick),
    .level(feed_level)
  );

  assign tick = (s_r.div == DIV_LAST);
  // an edge needs a tick and a queued feed word
  assign edge_now = tick && step_valid;
  assign accept = hsel && htrans[1] && hready;
  assign feed_valid = (s_r.bus == USR_BUS_WR) && is_feed(s_r.waddr);
  assign mode = usr_mode_e'({s_r.ctrl[CTRL_SEL_HI], s_r.ctrl[CTRL_SEL_LO]});

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.resp = 1'b0;
    s_nxt.div = tick ? '0 : DIV_W'(s_r.div + 1'b1);

    // Register stepping
    // stages change only on an edge
    if (edge_now)
    begin
      if (!s_r.ctrl[CTRL_CLR_N])
      begin
        s_nxt.stages = STAGES_RST;
      end
      else
      begin
        // mode acts whatever the pin drivers do
        unique case (mode)
          USR_LOAD:
          begin
            s_nxt.stages = par_pins_i;
          end
          USR_RIGHT:
          begin
            s_nxt.stages = {s_r.stages[STAGES-2:0], step_bits[FEED_RIGHT]};
          end
          USR_LEFT:
          begin
            s_nxt.stages = {step_bits[FEED_LEFT], s_r.stages[STAGES-1:1]};
          end
          USR_HOLD:
          begin
            s_nxt.stages = s_r.stages;
          end
        endcase
      end
    end

    // Bus slave
    unique case (s_r.bus)
      USR_BUS_IDLE:
      begin
        if (accept && hwrite)
        begin
          s_nxt.bus = USR_BUS_WR;
          s_nxt.waddr = haddr[ADDR_W-1:0];
          s_nxt.ready = 1'b0;
        end
        else if (accept)
        begin
          s_nxt.rdata = read_mux(haddr[ADDR_W-1:0], s_r, feed_level);
          s_nxt.ready = 1'b1;
        end
      end
      USR_BUS_WR:
      begin
        // A full feed queue holds the write in wait states
        if (!is_feed(s_r.waddr) || feed_ready)
        begin
          if (s_r.waddr == ADDR_CTRL)
          begin
            s_nxt.ctrl = hwdata[CTRL_W-1:0];
          end
          s_nxt.bus = USR_BUS_IDLE;
          s_nxt.ready = 1'b1;
        end
      end
    endcase

    s_nxt.low_tap = s_nxt.stages[0];
    s_nxt.high_tap = s_nxt.stages[STAGES-1];
    // drive enables track the new control value
    s_nxt.pin_oe = {STAGES{pins_driven(s_nxt.ctrl)}};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_r.ctrl <= CTRL_RST;
      s_r.stages <= STAGES_RST;
      s_r.pin_oe <= '0;
      s_r.low_tap <= 1'b0;
      s_r.high_tap <= 1'b0;
      s_r.rdata <= 32'h0000_0000;
      s_r.ready <= 1'b1;
      s_r.resp <= 1'b0;
      s_r.bus <= USR_BUS_IDLE;
      s_r.waddr <= '0;
      s_r.div <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // stages go straight to the pins
  assign par_pins_o = s_r.stages;
  assign par_pins_oe = s_r.pin_oe;
  assign low_end_tap = s_r.low_tap;
  assign high_end_tap = s_r.high_tap;
  assign hrdata = s_r.rdata;
  assign hreadyout = s_r.ready;
  assign hresp = s_r.resp;
endmodule
`default_nettype wire

/* test/usr_props.sv */
// Port assertions for the shift register block
`timescale 1ns/1ps
`default_nettype none
module usr_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // Pins
  input wire logic [usr_pkg::STAGES-1:0] par_pins_o,
  input wire logic [usr_pkg::STAGES-1:0] par_pins_oe,
  input wire logic low_end_tap,
  input wire logic high_end_tap
);
  import usr_pkg::*;
  logic tk;
  assign tk = hsel && htrans[1] && hready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_tap_low: assert property (low_end_tap == par_pins_o[0])
    else $error("low tap wrong");
  chk_tap_high: assert property (high_end_tap == par_pins_o[7])
    else $error("high tap wrong");
  chk_oe_all: assert property (par_pins_oe == '0 || par_pins_oe == '1)
    else $error("enables split");
  chk_oe_moment: assert property ($changed(par_pins_oe) |-> $rose(hreadyout))
    else $error("enable moved off write");
  chk_step_gap: assert property ($changed(par_pins_o) |=> $stable(par_pins_o) [*4])
    else $error("stages moved between steps");
  // Driven pins mean no load, so only clear or a shift may show
  chk_shift_form: assert property ($changed(par_pins_o) && $past(par_pins_oe[0]) |->
    (par_pins_o == '0 || par_pins_o[7:1] == $past(par_pins_o[6:0])
    || par_pins_o[6:0] == $past(par_pins_o[7:1])))
    else $error("bad stage move");
  chk_wr_wait: assert property (tk && hwrite |=> !hreadyout)
    else $error("write without wait");
  chk_rd_fast: assert property (tk && !hwrite |=> hreadyout)
    else $error("read waited");
  cover property (tk && hwrite);
  cover property ($rose(par_pins_oe[0]));
  cover property ($changed(par_pins_o) && !par_pins_oe[0]);
endmodule
`default_nettype wire

/* test/usr_pins.sv */
// Far-side logic on the parallel pins
`timescale 1ns/1ps
`default_nettype none
module usr_pins (
  // Clock
  input wire logic core_clk,
  // Block side
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_i,
  // Load data
  input wire logic drv_en,
  input wire logic [7:0] drv_val
);
  logic [7:0] last_r = 8'h00;
  always @(posedge core_clk)
  begin
    last_r <= pin_i;
  end
  // block drive reads back; released pins take load data if drv_en, else a toggling float
  assign pin_i = pin_oe[0] ? pin_o : (drv_en ? drv_val : ~last_r);
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the shift register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import usr_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic pe = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, lo_tap, hi_tap;
  logic [7:0] pin_i, pin_o, pin_oe, st;
  logic [7:0] pv = 8'h00;
  logic [7:0] r = 8'h45;
  logic [4:0] c;
  int err_total = 0;
  int checks = 0;
  always #10 core_clk = ~core_clk;
  usr_shift_top i_usr_shift_top (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .par_pins_i(pin_i), .par_pins_o(pin_o), .par_pins_oe(pin_oe),
    .low_end_tap(lo_tap), .high_end_tap(hi_tap));
  usr_pins i_usr_pins (.core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_i(pin_i), .drv_en(pe), .drv_val(pv));
  function automatic logic [7:0] lfsr(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] nx(logic [7:0] s, logic [4:0] k, logic [1:0] f);
    if (!k[2])
      return 8'h00;
    case (k[1:0])
      2'b11: return pv;
      2'b01: return {s[6:0], f[0]};
      2'b10: return {f[1], s[7:1]};
      default: return s;
    endcase
  endfunction
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic feed(input logic [1:0] f);
    ahb(1'b1, ADDR_FEED, {30'h0, f});
    st = nx(st, c, f);
  endtask
  task automatic step(input logic [4:0] k, input logic [1:0] f);
    // Pins are driven from outside only while loading
    pe <= (k[1:0] == 2'b11);
    ahb(1'b1, ADDR_CTRL, {27'h0, k});
    c = k;
    feed(f);
  endtask
  task automatic check_all;
    logic d;
    d = !c[3] && !c[4] && c[1:0] != 2'b11;
    q = 32'h100;
    for (int n = 0; n < 40 && q[11:8] != 4'h0; n++)
      ahb(1'b0, ADDR_STATE, 32'h0);
    cmp(q, {15'h0, d, 8'h0, st});
    cmp({16'h0, pin_oe, pin_o}, {16'h0, {8{d}}, st});
    cmp({30'h0, hi_tap, lo_tap}, {30'h0, st[7], st[0]});
    cmp({31'h0, hresp}, 32'h0);
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    st = 8'h00;
    c = CTRL_RST;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    ahb(1'b0, ADDR_CTRL, 32'h0);
    cmp(q, {27'h0, CTRL_RST});
    ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
    ahb(1'b0, 8'h0C, 32'h0);
    cmp(q, 32'h0);
    check_all;
    // Every mode in turn, clear low on every eighth pass
    for (int i = 0; i < 48; i++)
    begin
      r = lfsr(r);
      pv <= lfsr(r);
      step({r[4:3], i[2:0] != 3'h7, i[1:0]}, r[6:5]);
      check_all;
    end
    // Back-to-back feeds outrun the steps and fill the FIFO
    step(5'h05, r[1:0]);
    for (int j = 0; j < 24; j++)
    begin
      r = lfsr(r);
      feed(r[1:0]);
    end
    check_all;
    finish_test;
  end
  initial
  begin
    #1000000;
    err_total++;
    finish_test;
  end
endmodule
bind usr_shift_top usr_props i_usr_props (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .par_pins_o(par_pins_o), .par_pins_oe(par_pins_oe), .low_end_tap(low_end_tap),
  .high_end_tap(high_end_tap));
`default_nettype wire
